// ===== src/scan_sel_consts.vh
// constants for the scan range and sensor selection block
// included by bare name by every design file of the block
`ifndef SCAN_SEL_CONSTS_VH
`define SCAN_SEL_CONSTS_VH

`define ADDR_W            5
`define DATA_W            32
// register offsets
`define REG_CENTER        5'h00
`define REG_SPAN          5'h01
`define REG_START         5'h02
`define REG_STOP          5'h03
`define REG_IF_SPAN       5'h04
`define REG_IF_STEP       5'h05
`define REG_FUNC_ON       5'h06
`define REG_FUNC_OFF      5'h07
`define REG_MULTI_EN      5'h08
`define REG_STATUS        5'h09
`define REG_ERROR         5'h0a
`define REG_QUERY_SEL     5'h0b
`define REG_ON_COUNT      5'h0c
`define REG_OFF_COUNT     5'h0d
`define REG_TRACE_DATA    5'h0e
`define REG_TRACE_CLEARS  5'h0f
// query qualifier field in REG_QUERY_SEL
`define QSEL_CUR          2'h0
`define QSEL_MIN          2'h1
`define QSEL_MAX          2'h2
// sensor function bits: level, offset, field strength in query order
`define FN_LEVEL          0
`define FN_OFFSET         1
`define FN_FIELD          2
`define FN_RESET          3'h1
`define MULTI_RESET       1'h1
// error codes
`define ERR_NONE          8'h00
`define ERR_CONFLICT      8'hdd
`define ERR_PARAM         8'h6c
// frequency limits and reset values in hertz, and the number of IF span ranges
`define FREQ_MIN          32'h00_0f_42_40
`define FREQ_MAX          32'hb2_d0_5e_00
`define START_RESET       32'h07_07_8d_c0
`define STOP_RESET        32'h08_1b_32_00
`define IF_RANGES         8
`endif

// ===== src/if_span_table.v
// discrete IF panorama span ranges: rounds requests up, steps up and down
// assumes a single clock; result registered, valid one cycle after request
`timescale 1ns/1ps
`include "scan_sel_consts.vh"
module if_span_table #(
  parameter N = `IF_RANGES
) (
  input  wire        clk_in,    // clock
  input  wire        rst_in,    // async reset
  input  wire        set_in,    // round a requested value
  input  wire        up_in,     // step one range up
  input  wire        down_in,   // step one range down
  input  wire [31:0] value_in,  // requested span in hertz
  output reg  [2:0]  index_out, // current range index
  output reg  [31:0] span_out   // current range in hertz
);
  function [31:0] range_hz;
    input [2:0] i;
    begin
      case (i)
        3'h0: range_hz = 32'h0000_09c4;
        3'h1: range_hz = 32'h0000_1388;
        3'h2: range_hz = 32'h0000_2710;
        3'h3: range_hz = 32'h0000_61a8;
        3'h4: range_hz = 32'h0000_c350;
        3'h5: range_hz = 32'h0001_86a0;
        3'h6: range_hz = 32'h0003_d090;
        default: range_hz = 32'h0007_a120;
      endcase
    end
  endfunction

  reg  [2:0] next_index;
  wire [N-1:0] fits;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : cmp
      localparam [2:0] GI = g;
      assign fits[g] = (value_in <= range_hz(GI));
    end
  endgenerate

  integer k;
  always @* begin
    next_index = index_out;
    if (set_in) begin
      next_index = 3'h7;
      for (k = N - 1; k >= 0; k = k - 1)
        if (fits[k])
          next_index = k[2:0];
    end else if (up_in && index_out != 3'h7)
      next_index = index_out + 3'h1;
    else if (down_in && index_out != 3'h0)
      next_index = index_out - 3'h1;
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      index_out <= 3'h3;
      span_out  <= 32'h0000_61a8;
    end else begin
      index_out <= next_index;
      span_out  <= range_hz(next_index);
    end
  end
endmodule // if_span_table

// ===== src/trace_store.v
// small measurement trace buffer with registered read and bulk clear
// assumes a single clock; clear wins over a write in the same cycle
`timescale 1ns/1ps
`include "scan_sel_consts.vh"
module trace_store #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          clk_in,   // clock
  input  wire          rst_in,   // async reset
  input  wire          clear_in, // empty the data set
  input  wire          wr_in,    // append a sample
  input  wire [31:0]   data_in,  // sample
  input  wire [AW-1:0] raddr_in, // read address
  output reg  [31:0]   rdata_out // read data, zero for empty entries
);
  reg [31:0]    mem [0:DEPTH-1];
  reg [DEPTH-1:0] valid;
  reg [AW-1:0]  wptr;
  always @(posedge clk_in) begin
    if (wr_in)
      mem[wptr] <= data_in;
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid     <= {DEPTH{1'b0}};
      wptr      <= {AW{1'b0}};
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= valid[raddr_in] ? mem[raddr_in] : 32'h0000_0000;
      if (clear_in) begin
        valid <= {DEPTH{1'b0}};
        wptr  <= {AW{1'b0}};
      end else if (wr_in) begin
        valid[wptr] <= 1'b1;
        wptr        <= wptr + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // trace_store

// ===== src/scan_range_sensor_select.v
// settings handler: panorama range consistency and sensor function selection
// assumes a register master on clk_in that never needs wait states
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "scan_sel_consts.vh"
module scan_range_sensor_select #(
  parameter TRACE_DEPTH = 16
) (
  input  wire                clk_in,      // 20 MHz clock
  input  wire                rst_in,      // async reset, active high
  input  wire [`ADDR_W-1:0]  addr_in,     // register address
  input  wire [`DATA_W-1:0]  wdata_in,    // write data
  input  wire                wr_in,       // write strobe
  input  wire                rd_in,       // read strobe
  input  wire                sample_in,   // measurement sample strobe
  input  wire [31:0]         sample_in_d, // measurement sample value
  output reg  [`DATA_W-1:0]  rdata_out,   // read data, cycle after rd_in
  output reg  [2:0]          active_out,  // active sensor functions
  output reg  [31:0]         start_out,   // shared scan start
  output reg  [31:0]         stop_out,    // shared scan stop
  output reg                 error_out    // error register nonzero
);
  ////////////////////////////////////////////////////////////////////////////
  // panorama range
  reg  [31:0] start_f;
  reg  [31:0] stop_f;
  reg  [31:0] center_f;
  reg  [31:0] span_f;
  reg  [7:0]  err_code;
  reg  [1:0]  qsel;
  reg  [31:0] next_start;
  reg  [31:0] next_stop;
  reg         range_ok;
  reg         range_wr;
  wire        wr_center = wr_in && addr_in == `REG_CENTER;
  wire        wr_span   = wr_in && addr_in == `REG_SPAN;
  wire        wr_start  = wr_in && addr_in == `REG_START;
  wire        wr_stop   = wr_in && addr_in == `REG_STOP;
  wire [31:0] half_span = {1'b0, span_f[31:1]};
  wire [31:0] half_new  = {1'b0, wdata_in[31:1]};

  always @* begin
    next_start = start_f;
    next_stop  = stop_f;
    range_wr   = 1'b0;
    if (wr_center) begin
      next_start = wdata_in - half_span;
      next_stop  = wdata_in + half_span;
      range_wr   = 1'b1;
    end else if (wr_span) begin
      next_start = center_f - half_new;
      next_stop  = center_f + half_new;
      range_wr   = 1'b1;
    end else if (wr_start) begin
      next_start = wdata_in;
      range_wr   = 1'b1;
    end else if (wr_stop) begin
      next_stop = wdata_in;
      range_wr  = 1'b1;
    end
    range_ok = (next_start <= next_stop);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sensor functions
  reg         multi_en;
  reg  [2:0]  next_active;
  reg         param_err;
  wire        wr_on    = wr_in && addr_in == `REG_FUNC_ON;
  wire        wr_off   = wr_in && addr_in == `REG_FUNC_OFF;
  wire        wr_multi = wr_in && addr_in == `REG_MULTI_EN;
  wire [2:0]  named    = wdata_in[2:0];
  wire [1:0]  named_n  = {1'b0, named[0]} + {1'b0, named[1]} + {1'b0, named[2]};

  always @* begin
    next_active = active_out;
    param_err   = 1'b0;
    if (wr_on) begin
      if (multi_en)
        next_active = active_out | named;
      else if (named_n > 2'h1)
        param_err = 1'b1;
      else if (named_n == 2'h1)
        next_active = named;
    end else if (wr_off) begin
      next_active = active_out & ~named;
    end else if (wr_multi && multi_en && !wdata_in[0]) begin
      next_active = 3'h1 << `FN_LEVEL;
    end
  end

  wire trace_clear = (next_active != active_out);
  wire [1:0] on_cnt  = {1'b0, active_out[0]} + {1'b0, active_out[1]}
                     + {1'b0, active_out[2]};
  wire [1:0] off_cnt = 2'h3 - on_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // discrete IF span and trace buffer
  wire [2:0]  if_idx;
  wire [31:0] if_span;
  wire [31:0] trace_q;

  if_span_table u_if_span (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .set_in    (wr_in && addr_in == `REG_IF_SPAN),
    .up_in     (wr_in && addr_in == `REG_IF_STEP && wdata_in[0]),
    .down_in   (wr_in && addr_in == `REG_IF_STEP && wdata_in[1]),
    .value_in  (wdata_in),
    .index_out (if_idx),
    .span_out  (if_span)
  );

  trace_store #(
    .DEPTH (TRACE_DEPTH),
    .AW    (4)
  ) u_trace (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .clear_in  (trace_clear),
    .wr_in     (sample_in),
    .data_in   (sample_in_d),
    .raddr_in  (wdata_in[3:0]),
    .rdata_out (trace_q)
  );

  reg [15:0] clear_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // state update
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_f    <= `START_RESET;
      stop_f     <= `STOP_RESET;
      center_f   <= (`START_RESET + `STOP_RESET) >> 1;
      span_f     <= `STOP_RESET - `START_RESET;
      err_code   <= `ERR_NONE;
      qsel       <= `QSEL_CUR;
      multi_en   <= `MULTI_RESET;
      active_out <= `FN_RESET;
      clear_cnt  <= 16'h0000;
      start_out  <= `START_RESET;
      stop_out   <= `STOP_RESET;
      error_out  <= 1'b0;
    end else begin
      if (range_wr && range_ok) begin
        start_f   <= next_start;
        stop_f    <= next_stop;
        start_out <= next_start;
        stop_out  <= next_stop;
        span_f    <= next_stop - next_start;
        center_f  <= next_start + ((next_stop - next_start) >> 1);
      end
      if (range_wr && !range_ok) begin
        err_code  <= `ERR_CONFLICT;
        error_out <= 1'b1;
      end else if (param_err) begin
        err_code  <= `ERR_PARAM;
        error_out <= 1'b1;
      end else if (wr_in && addr_in == `REG_ERROR) begin
        err_code  <= `ERR_NONE;
        error_out <= 1'b0;
      end
      if (wr_in && addr_in == `REG_QUERY_SEL)
        qsel <= wdata_in[1:0];
      if (wr_multi)
        multi_en <= wdata_in[0];
      active_out <= next_active;
      if (trace_clear)
        clear_cnt <= clear_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  function [31:0] qual;
    input [31:0] cur;
    input [31:0] lo;
    input [31:0] hi;
    input [1:0]  q;
    begin
      case (q)
        `QSEL_MIN: qual = lo;
        `QSEL_MAX: qual = hi;
        default:   qual = cur;
      endcase
    end
  endfunction

  reg [31:0] next_rdata;
  always @* begin
    case (addr_in)
      `REG_CENTER:       next_rdata = qual(center_f, `FREQ_MIN, `FREQ_MAX, qsel);
      `REG_SPAN:         next_rdata = qual(span_f, 32'h0, `FREQ_MAX - `FREQ_MIN, qsel);
      `REG_START:        next_rdata = qual(start_f, `FREQ_MIN, `FREQ_MAX, qsel);
      `REG_STOP:         next_rdata = qual(stop_f, `FREQ_MIN, `FREQ_MAX, qsel);
      `REG_IF_SPAN:      next_rdata = qual(if_span, 32'h0000_09c4, 32'h0007_a120, qsel);
      `REG_IF_STEP:      next_rdata = {29'h0, if_idx};
      `REG_FUNC_ON:      next_rdata = {29'h0, active_out};
      `REG_FUNC_OFF:     next_rdata = {29'h0, ~active_out};
      `REG_MULTI_EN:     next_rdata = {31'h0, multi_en};
      `REG_STATUS:       next_rdata = {28'h0, multi_en, active_out};
      `REG_ERROR:        next_rdata = {24'h0, err_code};
      `REG_QUERY_SEL:    next_rdata = {30'h0, qsel};
      `REG_ON_COUNT:     next_rdata = {30'h0, on_cnt};
      `REG_OFF_COUNT:    next_rdata = {30'h0, off_cnt};
      `REG_TRACE_DATA:   next_rdata = trace_q;
      `REG_TRACE_CLEARS: next_rdata = {16'h0, clear_cnt};
      default:           next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      rdata_out <= 32'h0000_0000;
    else if (rd_in)
      rdata_out <= next_rdata;
    else
      rdata_out <= 32'h0000_0000;
  end
endmodule // scan_range_sensor_select

// ===== dv/remote_ctrl_model.sv
// remote controller model: issues register writes and reads to the block
// assumes read data stands in the cycle after the read strobe
`timescale 1ns/1ps
module remote_ctrl_model (
  input  wire        clk_in,    // clock
  input  wire [31:0] rdata_in,  // read data
  output reg  [4:0]  addr_out,  // address
  output reg  [31:0] wdata_out, // write data
  output reg         wr_out,    // write strobe
  output reg         rd_out     // read strobe
);
  initial begin
    addr_out = 5'h00;
    wdata_out = 32'h0000_0000;
    wr_out = 1'h0;
    rd_out = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // callers keep start not above stop and name one function in single mode,
  // except where a refusal is the point
  task wr(input [4:0] a, input [31:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'h1;
    @(posedge clk_in);
    wr_out <= 1'h0;
    @(posedge clk_in);
  endtask

  task rd(input [4:0] a, output [31:0] d);
    addr_out <= a;
    rd_out <= 1'h1;
    @(posedge clk_in);
    rd_out <= 1'h0;
    #1 d = rdata_in;
    @(posedge clk_in);
  endtask
endmodule // remote_ctrl_model

// ===== dv/scan_range_sensor_select_asserts.sv
// checker: port relations of the range and sensor selection block
// assumes only the top module's ports; bound at the foot of this file
`timescale 1ns/1ps
`include "scan_sel_consts.vh"
module scan_range_sensor_select_asserts #(
  parameter TRACE_DEPTH = 16
) (
  input wire        clk_in,     // clock
  input wire        rst_in,     // reset
  input wire [4:0]  addr_in,    // address
  input wire [31:0] wdata_in,   // write data
  input wire        wr_in,      // write strobe
  input wire [2:0]  active_out, // active set
  input wire [31:0] start_out,  // scan start
  input wire [31:0] stop_out,   // scan stop
  input wire        error_out   // error flag
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  start_reject_a: assert property (wr_in && addr_in == `REG_START && wdata_in > stop_out
    |=> error_out && start_out == $past(start_out)) else $error("start above stop taken");
  start_take_a: assert property (wr_in && addr_in == `REG_START && wdata_in <= stop_out
    |=> start_out == $past(wdata_in)) else $error("start write lost");
  stop_take_a: assert property (wr_in && addr_in == `REG_STOP && wdata_in >= start_out
    |=> stop_out == $past(wdata_in)) else $error("stop write lost");
  range_order_a: assert property (start_out <= stop_out) else $error("start above stop");
  range_hold_a: assert property (!(wr_in && addr_in <= `REG_STOP)
    |=> $stable(start_out) && $stable(stop_out)) else $error("range moved unasked");
  func_off_a: assert property (wr_in && addr_in == `REG_FUNC_OFF
    |=> active_out == ($past(active_out) & ~$past(wdata_in[2:0]))) else $error("off wrong");
  func_on_a: assert property (wr_in && addr_in == `REG_FUNC_ON && $onehot(wdata_in[2:0])
    |=> |(active_out & $past(wdata_in[2:0]))) else $error("named function not on");
  active_hold_a: assert property (!(wr_in && addr_in inside {`REG_FUNC_ON, `REG_FUNC_OFF,
    `REG_MULTI_EN}) |=> $stable(active_out)) else $error("active set moved unasked");
  err_clear_a: assert property (wr_in && addr_in == `REG_ERROR |=> !error_out)
    else $error("error not cleared");
endmodule // scan_range_sensor_select_asserts

bind scan_range_sensor_select scan_range_sensor_select_asserts #(
  .TRACE_DEPTH(TRACE_DEPTH)
) i_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .active_out(active_out), .start_out(start_out), .stop_out(stop_out),
  .error_out(error_out));

// ===== dv/scan_range_sensor_select_tb.sv
// testbench: panorama range, IF span steps and sensor function selection
// assumes the remote controller model drives the register port
`timescale 1ns/1ps
`include "scan_sel_consts.vh"
module scan_range_sensor_select_tb;
  reg          clk_in;
  reg          rst_in;
  reg          sample_in;
  reg  [31:0]  sample_in_d;
  wire [4:0]   addr_in;
  wire [31:0]  wdata_in;
  wire         wr_in;
  wire         rd_in;
  wire [31:0]  rdata_out;
  wire [2:0]   active_out;
  wire [31:0]  start_out;
  wire [31:0]  stop_out;
  wire         error_out;
  integer      err_count;
  integer      check_count;
  reg  [31:0]  v;
  reg  [31:0]  s;
  reg  [31:0]  h;
  reg  [31:0]  c;

  scan_range_sensor_select i_scan_range_sensor_select (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .sample_in(sample_in), .sample_in_d(sample_in_d), .rdata_out(rdata_out),
    .active_out(active_out), .start_out(start_out), .stop_out(stop_out),
    .error_out(error_out));
  remote_ctrl_model i_remote_ctrl_model (.clk_in(clk_in), .rdata_in(rdata_out),
    .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    i_remote_ctrl_model.wr(a, d);
  endtask
  task rchk(input string nm, input [4:0] a, input [31:0] e);
    i_remote_ctrl_model.rd(a, v);
    chk(nm, v, e);
  endtask
  task end_sim;
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("active", {29'h0, active_out}, 32'h1);
    chk("start", start_out, `START_RESET);
    rchk("multi", `REG_MULTI_EN, 32'h1);
    rchk("oncnt", `REG_ON_COUNT, 32'h1);
    rchk("offcnt", `REG_OFF_COUNT, 32'h2);
  endtask
  task t_range;
    s = `START_RESET - 32'h0010_0000;
    h = `STOP_RESET - s;
    wr(`REG_START, s);
    chk("start", start_out, s);
    rchk("center", `REG_CENTER, s + h / 2);
    rchk("span", `REG_SPAN, h);
    c = s + 32'h0004_0000;
    wr(`REG_CENTER, c);
    chk("start", start_out, c - h / 2);
    chk("stop", stop_out, c + h / 2);
    wr(`REG_SPAN, 32'h0002_0000);
    chk("start", start_out, c - 32'h0001_0000);
    chk("stop", stop_out, c + 32'h0001_0000);
    wr(`REG_STOP, c - 32'h0001_0000);
    chk("stop", stop_out, c - 32'h0001_0000);
    rchk("span", `REG_SPAN, 32'h0);
    wr(`REG_START, c);
    chk("errflag", {31'h0, error_out}, 32'h1);
    chk("start", start_out, c - 32'h0001_0000);
    rchk("errcode", `REG_ERROR, {24'h0, `ERR_CONFLICT});
    wr(`REG_ERROR, 32'h0);
    wr(`REG_QUERY_SEL, {30'h0, `QSEL_MIN});
    rchk("startmin", `REG_START, `FREQ_MIN);
    wr(`REG_QUERY_SEL, {30'h0, `QSEL_MAX});
    rchk("stopmax", `REG_STOP, `FREQ_MAX);
    wr(`REG_QUERY_SEL, {30'h0, `QSEL_CUR});
    rchk("start", `REG_START, c - 32'h0001_0000);
  endtask
  task t_ifspan;
    wr(`REG_IF_SPAN, 32'h0000_09c4);
    rchk("ifmin", `REG_IF_SPAN, 32'h0000_09c4);
    wr(`REG_IF_SPAN, 32'h0000_09c5);
    i_remote_ctrl_model.rd(`REG_IF_SPAN, h);
    chk("ifup", {31'h0, h > 32'h0000_09c4}, 32'h1);
    wr(`REG_IF_STEP, 32'h2);
    rchk("ifdown", `REG_IF_SPAN, 32'h0000_09c4);
    wr(`REG_IF_STEP, 32'h1);
    rchk("ifstep", `REG_IF_SPAN, h);
  endtask
  task t_func;
    i_remote_ctrl_model.rd(`REG_TRACE_CLEARS, s);
    sample_in <= 1'h1;
    @(posedge clk_in);
    sample_in <= 1'h0;
    wr(`REG_QUERY_SEL, 32'h0);
    i_remote_ctrl_model.rd(`REG_TRACE_DATA, v);
    rchk("trace", `REG_TRACE_DATA, 32'h0000_5a5a);
    wr(`REG_FUNC_ON, 32'h2);
    chk("active", {29'h0, active_out}, 32'h3);
    wr(`REG_QUERY_SEL, 32'h0);
    i_remote_ctrl_model.rd(`REG_TRACE_DATA, v);
    rchk("traceclr", `REG_TRACE_DATA, 32'h0);
    wr(`REG_FUNC_OFF, 32'h1);
    chk("active", {29'h0, active_out}, 32'h2);
    rchk("offlist", `REG_FUNC_OFF, 32'h5);
    rchk("oncnt", `REG_ON_COUNT, 32'h1);
    rchk("offcnt", `REG_OFF_COUNT, 32'h2);
    rchk("clears", `REG_TRACE_CLEARS, s + 32'h2);
    wr(`REG_MULTI_EN, 32'h0);
    chk("active", {29'h0, active_out}, 32'h1);
    wr(`REG_FUNC_ON, 32'h4);
    chk("active", {29'h0, active_out}, 32'h4);
    wr(`REG_FUNC_ON, 32'h3);
    chk("active", {29'h0, active_out}, 32'h4);
    rchk("errcode", `REG_ERROR, {24'h0, `ERR_PARAM});
    wr(`REG_ERROR, 32'h0);
    chk("errflag", {31'h0, error_out}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count = err_count + 1;
    end_sim;
  end
  initial begin
    err_count = 0;
    check_count = 0;
    rst_in = 1'h1;
    sample_in = 1'h0;
    sample_in_d = 32'h0000_5a5a;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
    #1;
    t_reset;
    t_range;
    t_ifspan;
    t_func;
    end_sim;
  end
endmodule // scan_range_sensor_select_tb
